/* rtl/pic_ctrl.sv */
// Fifteen-channel prioritising interrupt controller, top level.
// Assumes a single-cycle register port and inputs in the clk_sys domain.
//
// Functional notes
// - Two trigger registers: channels 8-15 and 1-7
// - Trigger field: high, low, rising, falling
// - Pinless channels held low internally
// - Detected trigger sets channel pending bit
// - Pending register read-only, reset zero, bit0 zero
// - Mode 00 passes external level unchanged
// - Mode 01 enables channels 15 to 8
// - Mode field bits 1:0, reset 00
// - Highest unmasked pending channel goes to latch
// - Global mask blocks forwarding, latch still loads
// - Latch-clear write empties latch for next
// - Reset sets every mask bit
// - Request-clear bit n clears pending bit n
// - Latched zero means no request
// - Masked pending bits stay readable
// - Fifteen levels, highest level non-maskable
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_ctrl (
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic [11:1] request_channel_line,
   input  wire logic [3:0]  encoded_level_lines,
   output logic      [3:0]  iu_level
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic        [15:0] trig_hi_reg;
   logic        [15:0] trig_hi_next;
   logic        [15:0] trig_lo_reg;
   logic        [15:0] trig_lo_next;
   logic        [15:0] mask_reg;
   logic        [15:0] mask_next;
   logic        [1:0]  mode_reg;
   logic        [1:0]  mode_next;
   logic        [15:0] pend_reg;
   logic        [15:0] pend_next;
   logic        [3:0]  latch_reg;
   logic        [3:0]  latch_next;
   pic_pkg::pic_lat_st_t lat_st_reg;
   pic_pkg::pic_lat_st_t lat_st_next;
   logic        [3:0]  iu_level_reg;
   logic        [3:0]  iu_level_next;
   logic        [31:0] rdata_reg;
   logic        [31:0] rdata_next;
   logic               mode_on;
   logic               wr_trig_hi;
   logic               wr_trig_lo;
   logic               wr_mask;
   logic               wr_latch;
   logic               wr_req_clr;
   logic               wr_mode;
   logic               clear_latch;
   logic        [15:1] clr_bits;
   logic        [15:1] unmasked;
   logic        [3:0]  top_level;

   pic_det_if det_bus ();

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   // One strobe at a time, so one decode per offset is enough
   always_comb begin
      wr_trig_hi = reg_wr && (reg_addr == `PIC_OFF_TRIG_HI);
      wr_trig_lo = reg_wr && (reg_addr == `PIC_OFF_TRIG_LO);
      wr_mask    = reg_wr && (reg_addr == `PIC_OFF_MASK);
      wr_latch   = reg_wr && (reg_addr == `PIC_OFF_LATCH);
      wr_req_clr = reg_wr && (reg_addr == `PIC_OFF_REQ_CLR);
      wr_mode    = reg_wr && (reg_addr == `PIC_OFF_MODE);
   end

   assign mode_on     = (mode_reg == `PIC_MODE_ON);
   assign clear_latch = wr_latch && reg_wdata[`PIC_CL_BIT];
   assign clr_bits    = wr_req_clr ? reg_wdata[15:1] : 15'h0000;

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Mode is stored as written; reserved codes act as disabled but forward no level
   always_comb begin
      trig_hi_next = trig_hi_reg;
      trig_lo_next = trig_lo_reg;
      mask_next    = mask_reg;
      mode_next    = mode_reg;
      if (wr_trig_hi) begin
         trig_hi_next = reg_wdata[15:0];
      end
      if (wr_trig_lo) begin
         trig_lo_next = {reg_wdata[15:2], 2'b00};
      end
      if (wr_mask) begin
         mask_next = reg_wdata[15:0];
      end
      if (wr_mode) begin
         mode_next = reg_wdata[1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         trig_hi_reg <= `PIC_TRIG_RST;
         trig_lo_reg <= `PIC_TRIG_RST;
         mask_reg    <= `PIC_MASK_RST;
         mode_reg    <= `PIC_MODE_OFF;
      end else begin
         trig_hi_reg <= trig_hi_next;
         trig_lo_reg <= trig_lo_next;
         mask_reg    <= mask_next;
         mode_reg    <= mode_next;
      end
   end

   // ----------------------------------------
   // Request lines into the detector
   // ----------------------------------------
   // Channels 8-15 have no pin while disabled; they see a steady low
   always_comb begin
      det_bus.raw_line[7:1] = request_channel_line[7:1];
      if (mode_on) begin
         det_bus.raw_line[11:8]  = request_channel_line[11:8];
         det_bus.raw_line[15:12] = encoded_level_lines;
      end else begin
         det_bus.raw_line[15:8] = 8'h00;
      end
   end

   // Trigger fields: two bits per channel, channel order upward
   for (genvar ch = 1; ch <= 15; ch++) begin : g_trig
      if (ch >= 8) begin : g_hi
         assign det_bus.trig_sel[ch] =
            pic_pkg::pic_trig_t'(trig_hi_reg[2*(ch-8) +: 2]);
      end else begin : g_lo
         assign det_bus.trig_sel[ch] =
            pic_pkg::pic_trig_t'(trig_lo_reg[2*ch +: 2]);
      end
   end

   pic_trigger_det u_det (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .det     (det_bus.det)
   );

   // ----------------------------------------
   // Pending flags
   // ----------------------------------------
   // Event set is ORed after the clear so a same-cycle event survives
   always_comb begin
      pend_next      = pend_reg;
      pend_next[15:1] = (pend_reg[15:1] & ~clr_bits)
                      | det_bus.event_hit;
      pend_next[0]   = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pend_reg <= 16'h0000;
      end else begin
         pend_reg <= pend_next;
      end
   end

   // ----------------------------------------
   // Priority and level latch
   // ----------------------------------------
   // Mask bits 15:1 gate only the encoder; pending itself is never masked
   assign unmasked = pend_reg[15:1] & ~mask_reg[15:1];

   pic_prio_enc u_enc (
      .req   (unmasked),
      .level (top_level)
   );

   // Latch holds until acknowledged, so a later higher request waits.
   // Loading right after a clear would re-take a stale request if the
   // pending bit was not cleared first; software orders that.
   always_comb begin
      lat_st_next = lat_st_reg;
      latch_next  = latch_reg;
      case (lat_st_reg)
         pic_pkg::PIC_LAT_EMPTY: begin
            if (mode_on && (top_level != `PIC_LEVEL_NONE)) begin
               latch_next  = top_level;
               lat_st_next = pic_pkg::PIC_LAT_HELD;
            end
         end
         pic_pkg::PIC_LAT_HELD: begin
            if (clear_latch) begin
               latch_next  = `PIC_LEVEL_NONE;
               lat_st_next = pic_pkg::PIC_LAT_EMPTY;
            end
         end
         default: begin
            latch_next  = `PIC_LEVEL_NONE;
            lat_st_next = pic_pkg::PIC_LAT_EMPTY;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lat_st_reg <= pic_pkg::PIC_LAT_EMPTY;
         latch_reg  <= `PIC_LEVEL_NONE;
      end else begin
         lat_st_reg <= lat_st_next;
         latch_reg  <= latch_next;
      end
   end

   // ----------------------------------------
   // Level toward the integer unit
   // ----------------------------------------
   // Level 15 is passed like any other; the processor treats it as
   // non-maskable. Reserved mode codes forward nothing.
   always_comb begin
      case (mode_reg)
         `PIC_MODE_OFF: iu_level_next = encoded_level_lines;
         `PIC_MODE_ON: begin
            if (mask_reg[`PIC_GMASK_BIT]) begin
               iu_level_next = `PIC_LEVEL_NONE;
            end else begin
               iu_level_next = latch_reg;
            end
         end
         default:       iu_level_next = `PIC_LEVEL_NONE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         iu_level_reg <= `PIC_LEVEL_NONE;
      end else begin
         iu_level_reg <= iu_level_next;
      end
   end

   assign iu_level = iu_level_reg;

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Data stands only in the cycle after the strobe; zero otherwise,
   // and zero for unmapped or write-only offsets
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            `PIC_OFF_TRIG_HI: rdata_next = {16'h0000, trig_hi_reg};
            `PIC_OFF_TRIG_LO: rdata_next = {16'h0000, trig_lo_reg};
            `PIC_OFF_PENDING: rdata_next = {16'h0000, pend_reg};
            `PIC_OFF_MASK:    rdata_next = {16'h0000, mask_reg};
            `PIC_OFF_LATCH:   rdata_next = {28'h000_0000, latch_reg};
            `PIC_OFF_MODE:    rdata_next = {30'h0000_0000, mode_reg};
            default:          rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
endmodule

/* rtl/pic_regs.svh */
// Register offsets, field positions, reset values of the interrupt block.
// Assumes a 32-bit register port with byte addresses, one word per register.
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PIC_ADDR_W        8
`define PIC_OFF_TRIG_HI   8'h00
`define PIC_OFF_TRIG_LO   8'h04
`define PIC_OFF_PENDING   8'h08
`define PIC_OFF_MASK      8'h0C
`define PIC_OFF_LATCH     8'h10
`define PIC_OFF_REQ_CLR   8'h14
`define PIC_OFF_MODE      8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PIC_CL_BIT        4
`define PIC_GMASK_BIT     0
`define PIC_MODE_OFF      2'h0
`define PIC_MODE_ON       2'h1
`define PIC_MASK_RST      16'hFFFF
`define PIC_TRIG_RST      16'h0000
`define PIC_LEVEL_NONE    4'h0
`define PIC_FIRST_PIN_HI  12

`endif

/* rtl/pic_pkg.sv */
// Types shared by the interrupt block modules.
// Assumes the constants of pic_regs.svh for offsets and fields.
package pic_pkg;

   // Per-channel trigger choice
   typedef enum logic [1:0] {
      PIC_TRG_HIGH = 2'b00,
      PIC_TRG_LOW  = 2'b01,
      PIC_TRG_RISE = 2'b10,
      PIC_TRG_FALL = 2'b11
   } pic_trig_t;

   // Level latch occupancy, Gray along empty -> held
   typedef enum logic [1:0] {
      PIC_LAT_EMPTY = 2'b00,
      PIC_LAT_HELD  = 2'b01
   } pic_lat_st_t;

endpackage

/* rtl/pic_det_if.sv */
// Carrier between the controller core and its trigger detector.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface pic_det_if;
   logic                  [15:1] raw_line;
   pic_pkg::pic_trig_t    [15:1] trig_sel;
   logic                  [15:1] event_hit;

   modport det (input raw_line, input trig_sel, output event_hit);
   modport ctl (output raw_line, output trig_sel, input event_hit);
endinterface

/* rtl/pic_trigger_det.sv */
// Per-channel synchroniser and trigger detector.
// Assumes raw lines may change at any time relative to clk_sys.
`timescale 1ns/1ps
module pic_trigger_det (
   input  wire logic clk_sys,
   input  wire logic arst_n,
   pic_det_if.det    det
);
   logic [15:1] meta_reg;
   logic [15:1] sync_reg;
   logic [15:1] prev_reg;
   logic [15:1] sync_next;
   logic [15:1] prev_next;

   // ----------------------------------------
   // Synchroniser and previous sample
   // ----------------------------------------
   // Only the second stage and its previous sample are looked at; first stage may be metastable
   always_comb begin
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= 15'h0000;
         sync_reg <= 15'h0000;
         prev_reg <= 15'h0000;
      end else begin
         meta_reg <= det.raw_line;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   // ----------------------------------------
   // Trigger compare per channel
   // ----------------------------------------
   for (genvar ch = 1; ch <= 15; ch++) begin : g_ch
      // Edges last one cycle; levels hold while the line holds
      always_comb begin
         case (det.trig_sel[ch])
            pic_pkg::PIC_TRG_HIGH: det.event_hit[ch] = sync_reg[ch];
            pic_pkg::PIC_TRG_LOW:  det.event_hit[ch] = ~sync_reg[ch];
            pic_pkg::PIC_TRG_RISE: det.event_hit[ch] = sync_reg[ch] & ~prev_reg[ch];
            pic_pkg::PIC_TRG_FALL: det.event_hit[ch] = ~sync_reg[ch] & prev_reg[ch];
            default:               det.event_hit[ch] = 1'b0;
         endcase
      end
   end
endmodule

/* rtl/pic_prio_enc.sv */
// Priority encoder: highest set channel number wins, 0 when none.
// Assumes bit n of the request vector stands for channel n.
`timescale 1ns/1ps
module pic_prio_enc (
   input  wire logic [15:1] req,
   output logic      [3:0]  level
);
   // ----------------------------------------
   // Scan upward so the last hit is the highest
   // ----------------------------------------
   always_comb begin
      level = 4'h0;
      for (int ch = 1; ch <= 15; ch++) begin
         if (req[ch]) begin
            level = ch[3:0];
         end
      end
   end
endmodule

/* verif/pic_ctrl_assertions.sv */
// Port checker for the interrupt block top level.
// Assumes bind onto pic_ctrl, one clock, async active-low reset.
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_ctrl_assertions (
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        clk_sys,
   input wire logic        arst_n,
   input wire logic [11:1] request_channel_line,
   input wire logic [3:0]  encoded_level_lines,
   input wire logic [3:0]  iu_level
);
   // ---------
   // Shadow state
   // ---------
   logic [1:0] mode_reg;
   logic       gmask_reg;
   logic       alive_reg;
   logic       cl_w;
   // Latch-clear write seen on the bus
   assign cl_w = reg_wr && reg_addr == `PIC_OFF_LATCH && reg_wdata[`PIC_CL_BIT];
   // Mode and global mask copied from writes; alive skips the reset edge
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_reg  <= 2'h0;
         gmask_reg <= 1'h1;
         alive_reg <= 1'h0;
      end else begin
         alive_reg <= 1'h1;
         if (reg_wr && reg_addr == `PIC_OFF_MODE) mode_reg <= reg_wdata[1:0];
         if (reg_wr && reg_addr == `PIC_OFF_MASK) gmask_reg <= reg_wdata[0];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Read data only in the slot after a read strobe
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_pend_rsvd;
      $past(reg_rd) && $past(reg_addr) == `PIC_OFF_PENDING
         |-> reg_rdata[0] == 1'h0 && reg_rdata[31:16] == 16'h0000;
   endproperty
   a_pend_rsvd: assert property (p_pend_rsvd) else $error("pending reserved bits");
   property p_mode_rsvd;
      $past(reg_rd) && $past(reg_addr) == `PIC_OFF_MODE |-> reg_rdata[31:2] == 30'h0000_0000;
   endproperty
   a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode upper bits");
   property p_pass;
      alive_reg && $past(mode_reg) == 2'h0 |-> iu_level == $past(encoded_level_lines);
   endproperty
   a_pass: assert property (p_pass) else $error("level not passed through");
   property p_gmask;
      alive_reg && $past(mode_reg) == 2'h1 && $past(gmask_reg) |-> iu_level == 4'h0;
   endproperty
   a_gmask: assert property (p_gmask) else $error("level forwarded while masked");
   property p_cl; cl_w && mode_reg == 2'h1 |-> ##2 iu_level == 4'h0; endproperty
   a_cl: assert property (p_cl) else $error("latch clear ignored");
   // Latch holds its level until cleared, even if higher requests arrive
   property p_hold;
      iu_level != 4'h0 && mode_reg == 2'h1 && $past(mode_reg) == 2'h1 && !gmask_reg && !cl_w
         && !$past(cl_w) |=> $stable(iu_level);
   endproperty
   a_hold: assert property (p_hold) else $error("latched level changed");
   property p_reset; !alive_reg |-> iu_level == 4'h0 && reg_rdata == 32'h0000_0000; endproperty
   a_reset: assert property (p_reset) else $error("outputs not idle after reset");
endmodule
bind pic_ctrl pic_ctrl_assertions u_chk (
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .clk_sys(clk_sys), .arst_n(arst_n),
   .request_channel_line(request_channel_line),
   .encoded_level_lines(encoded_level_lines), .iu_level(iu_level)
);

/* verif/pic_far_model.sv */
// Far side: request sources and the integer unit's level input.
// Assumes the bench sets wanted line levels on clk_sys edges.
`timescale 1ns/1ps
module pic_far_model (
   input  wire logic        clk_sys,
   input  wire logic [11:1] want_lines,
   input  wire logic [3:0]  want_enc,
   input  wire logic [3:0]  iu_level,
   output logic      [11:1] request_channel_line,
   output logic      [3:0]  encoded_level_lines,
   output logic      [3:0]  last_trap
);
   // Known levels from time zero so nothing floats into the synchroniser
   initial begin
      request_channel_line = 11'h000;
      encoded_level_lines  = 4'h0;
      last_trap            = 4'h0;
   end
   // Sources move just after an edge, like off-chip logic would
   always @(posedge clk_sys) begin
      request_channel_line <= want_lines;
      encoded_level_lines  <= want_enc;
      if (iu_level != 4'h0) last_trap <= iu_level;
   end
endmodule

/* verif/prioritizing_interrupt_controller_test.sv */
// Self-checking bench for the interrupt block.
// Assumes pic_ctrl with checker bound and the far side model.
`timescale 1ns/1ps
`include "pic_regs.svh"
module prioritizing_interrupt_controller_test;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic        clk_sys;
   logic        arst_n;
   logic [11:1] want_lines;
   logic [3:0]  want_enc;
   wire  [31:0] reg_rdata;
   wire  [11:1] request_channel_line;
   wire  [3:0]  encoded_level_lines;
   wire  [3:0]  iu_level;
   wire  [3:0]  last_trap;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   pic_ctrl DUT (.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_sys(clk_sys), .arst_n(arst_n),
      .request_channel_line(request_channel_line),
      .encoded_level_lines(encoded_level_lines), .iu_level(iu_level));
   pic_far_model u_far (.clk_sys(clk_sys), .want_lines(want_lines), .want_enc(want_enc),
      .iu_level(iu_level), .request_channel_line(request_channel_line),
      .encoded_level_lines(encoded_level_lines), .last_trap(last_trap));
   // ---------
   // Bus and check tasks
   // ---------
   always #25 clk_sys = ~clk_sys;
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask
   // Data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      @(negedge clk_sys);
      check(reg_rdata, exp);
   endtask
   task automatic wait_iu(input logic [3:0] exp);
      int k;
      k = 0;
      while (iu_level !== exp && k < 40) begin
         @(negedge clk_sys);
         k++;
      end
      check({28'h000_0000, iu_level}, {28'h000_0000, exp});
      if (k == 40) close_out();
   endtask
   // ---------
   // Scenarios
   // ---------
   task automatic t_reset();
      rd(`PIC_OFF_MODE, 32'h0000_0000);
      rd(`PIC_OFF_PENDING, 32'h0000_0000);
      rd(`PIC_OFF_MASK, 32'h0000_FFFF);
      wr(`PIC_OFF_PENDING, 32'h0000_FFFF);
      rd(`PIC_OFF_PENDING, 32'h0000_0000);
      wr(`PIC_OFF_MODE, 32'hFFFF_FFFD);
      rd(`PIC_OFF_MODE, 32'h0000_0001);
      wr(`PIC_OFF_MODE, 32'h0000_0000);
      rd(8'h1C, 32'h0000_0000);
      $display("reset test done");
   endtask
   task automatic t_pass();
      @(posedge clk_sys);
      want_enc <= 4'hA;
      wait_iu(4'hA);
      @(posedge clk_sys);
      want_enc <= 4'h0;
      wait_iu(4'h0);
      $display("pass-through test done");
   endtask
   // Channel 3 through all four trigger choices; idle level is bit 0 of the code
   task automatic t_trig();
      logic idle;
      for (int m = 0; m < 4; m++) begin
         idle = m[0];
         @(posedge clk_sys);
         want_lines <= idle ? 11'h004 : 11'h000;
         wr(`PIC_OFF_TRIG_LO, 32'(m) << 6);
         tick(4);
         wr(`PIC_OFF_REQ_CLR, 32'h0000_0008);
         rd(`PIC_OFF_PENDING, 32'h0000_0000);
         @(posedge clk_sys);
         want_lines <= idle ? 11'h000 : 11'h004;
         tick(5);
         rd(`PIC_OFF_PENDING, 32'h0000_0008);
         wr(`PIC_OFF_REQ_CLR, 32'h0000_0008);
         rd(`PIC_OFF_PENDING, m[1] ? 32'h0000_0000 : 32'h0000_0008);
      end
      wr(`PIC_OFF_TRIG_HI, 32'h0000_0004);
      tick(5);
      rd(`PIC_OFF_PENDING, 32'h0000_0200);
      wr(`PIC_OFF_TRIG_HI, 32'h0000_0000);
      $display("trigger test done");
   endtask
   task automatic t_prio();
      wr(`PIC_OFF_TRIG_LO, 32'h0000_0000);
      wr(`PIC_OFF_REQ_CLR, 32'h0000_FFFE);
      wr(`PIC_OFF_MODE, 32'h0000_0001);
      want_lines <= 11'h012;
      want_enc   <= 4'h4;
      tick(6);
      want_lines <= 11'h000;
      rd(`PIC_OFF_PENDING, 32'h0000_4024);
      wr(`PIC_OFF_MASK, 32'h0000_FFDA);
      wait_iu(4'h5);
      wr(`PIC_OFF_REQ_CLR, 32'h0000_0020);
      wr(`PIC_OFF_LATCH, 32'h0000_0010);
      wait_iu(4'h2);
      wr(`PIC_OFF_MASK, 32'h0000_FFDB);
      wait_iu(4'h0);
      rd(`PIC_OFF_LATCH, 32'h0000_0002);
      check({28'h000_0000, last_trap}, 32'h0000_0002);
      wr(`PIC_OFF_REQ_CLR, 32'h0000_0004);
      wr(`PIC_OFF_LATCH, 32'h0000_0010);
      rd(`PIC_OFF_LATCH, 32'h0000_0000);
      wr(`PIC_OFF_MASK, 32'h0000_BFDB);
      tick(4);
      rd(`PIC_OFF_LATCH, 32'h0000_000E);
      want_enc <= 4'h0;
      wr(`PIC_OFF_MODE, 32'h0000_0000);
      $display("priority test done");
   endtask
   initial begin
      clk_sys    = 1'h0;
      arst_n     = 1'h0;
      reg_addr   = 8'h00;
      reg_wdata  = 32'h0000_0000;
      reg_wr     = 1'h0;
      reg_rd     = 1'h0;
      want_lines = 11'h000;
      want_enc   = 4'h0;
      tick(10);
      arst_n <= 1'h1;
      t_reset();
      t_pass();
      t_trig();
      t_prio();
      close_out();
   end
endmodule
